// File: logic/obc_map.svh
`ifndef OBC_MAP_SVH
`define OBC_MAP_SVH

// register byte offsets
`define OBC_REG_CTRL      8'h00
`define OBC_REG_STATUS    8'h04
`define OBC_REG_EOC       8'h08
`define OBC_REG_FAR_END_ERROR_FLAG      8'h0C

// control register fields
`define OBC_CTRL_TEST     0
`define OBC_CTRL_CSO      1
`define OBC_CTRL_ACT      2
`define OBC_CTRL_W        3
`define OBC_CTRL_RESET    3'h4

// status register fields
`define OBC_ST_FULL       0
`define OBC_ST_B1         1
`define OBC_ST_B2         2
`define OBC_ST_CORRUPT    3
`define OBC_ST_NOTIFY     4
`define OBC_ST_PS_LO      5
`define OBC_ST_PS_HI      6
`define OBC_ST_DEACT      7
`define OBC_ST_ACT        8

// operations frame layout and codes
`define OBC_ADDR_NT       3'h0
`define OBC_ADDR_BCAST    3'h7
`define OBC_DM_MSG        1'h1
`define OBC_MSG_FULL      8'h50
`define OBC_MSG_B1        8'h51
`define OBC_MSG_B2        8'h52
`define OBC_MSG_REQ_CRC   8'h53
`define OBC_MSG_NOTE_CRC  8'h54
`define OBC_MSG_RTN       8'hFF
`define OBC_MSG_HOLD      8'h00
`define OBC_MSG_UTC       8'hAA
`define OBC_EOC_RESET     12'h000

// counts and power codes
`define OBC_REPEAT        2'h3
`define OBC_GASP_MF       2'h3
`define OBC_DEA_MF        2'h3
`define OBC_PS_DYING      2'h0
`define OBC_PS_NORMAL     2'h3
`define OBC_RESERVED3     3'h7
`define OBC_FAR_END_ERROR_FLAG_CNT_W    16

`endif

// File: logic/obc_pkg.sv
package obc_pkg;

  typedef enum logic [0:0] {
    obc_apb_idle = 1'b0,
    obc_apb_resp = 1'b1
  } obc_apb_state_t;

  typedef logic [11:0] obc_eoc_frame_t;

endpackage : obc_pkg

// File: logic/obc_sync2.sv
`timescale 1ns/1ps

module obc_sync2 #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule : obc_sync2

// File: logic/obc_top.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "obc_map.svh"

// What this block does
// - Far-end error flag is ONE for a clean received multiframe, ZERO on check error.
// - That flag goes out in the next outgoing multiframe.
// - Activation flag sits in overhead bit four of basic frame one, both ways.
// - Power status bits: 11 normal, 10 secondary out, 01 primary out, 00 dying gasp.
// - Dying gasp, once sent, is sent for at least three multiframes.
// - Test-mode flag ONE normally, ZERO during customer local maintenance.
// - Cold-start-only flag in frame five: ONE if cold-start-only, else ZERO in startup.
// - Unassigned overhead bits four to six are sent as ONE.
// - Two twelve-bit operations frames per multiframe from overhead bits one to three.
// - Frame is 3-bit address, 1-bit data/message indicator, 8-bit information.
// - Indicator ONE means message, ZERO means numerical data.
// - Act only on three identical consecutive addressed frames with a known message.
// - Answer every frame, normally echo, in the next frame; never unsolicited.
// - Unknown message: echo twice, then unable-to-comply with address 000.
// - Foreign address: reply hold-state with address 000.
// - Actions stay latched together; hold-state changes nothing.
// - Full loopback returns both B channels and D towards the network.
// - Single-channel loopback returns only the chosen B channel.
// - Return-to-normal releases all actions and resets the processor.
// - Corrupt-check request corrupts sent check codes until return-to-normal.
// - Loopback and check-code message codes 0x50 to 0x54.
// - Return-to-normal 0xFF, hold-state 0x00, unable-to-comply 0xAA.

module obc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_mf_done,
  input  wire logic              rx_crc_err,
  input  wire logic              rx_act_bit,
  input  wire logic              rx_dea_bit,
  input  wire logic              rx_far_end_error_flag_bit,
  input  wire logic              rx_eoc_valid,
  input  wire logic [11:0]       rx_eoc_frame,
  input  wire logic              tx_mf_load,
  input  wire logic              sn3_active,
  input  wire logic              primary_power_ok,
  input  wire logic              secondary_power_ok,
  output logic                   tx_eoc_valid,
  output logic      [11:0]       tx_eoc_frame,
  output logic      [7:0]        tx_m4_bits,
  output logic      [3:0]        tx_m56_bits,
  output logic                   loop_full,
  output logic                   loop_b1,
  output logic                   loop_b2,
  output logic                   tx_corrupt_crc
);

  // power pins come from outside the clock domain
  logic [1:0] power_sync;

  obc_sync2 #(
    .W (2)
  ) u_power_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .d        ({primary_power_ok, secondary_power_ok}),
    .q        (power_sync)
  );

  // ---------------------------------------------------------------- apb slave
  obc_pkg::obc_apb_state_t        apb_state_reg;
  logic [31:0]                    prdata_reg;
  logic                           pready_reg;
  logic                           pslverr_reg;
  logic [`OBC_CTRL_W-1:0]         ctrl_reg;
  logic                           far_end_error_flag_clr;
  logic                           commit_wr;
  logic                           addr_hit;
  logic [31:0]                    rd_mux;

  // processor and overhead state
  obc_pkg::obc_eoc_frame_t        last_frame_reg;
  logic [1:0]                     rep_cnt_reg;
  obc_pkg::obc_eoc_frame_t        tx_eoc_frame_reg;
  logic                           tx_eoc_valid_reg;
  logic                           loop_full_reg;
  logic                           loop_b1_reg;
  logic                           loop_b2_reg;
  logic                           corrupt_reg;
  logic                           notify_reg;
  logic                           far_end_error_flag_pending_reg;
  logic [`OBC_FAR_END_ERROR_FLAG_CNT_W-1:0]     far_end_error_flag_cnt_reg;
  logic [1:0]                     dea_cnt_reg;
  logic                           rx_act_reg;
  logic [1:0]                     gasp_cnt_reg;
  logic [1:0]                     ps_sent_reg;
  logic [7:0]                     tx_m4_reg;
  logic [3:0]                     tx_m56_reg;

  // decode of the received operations frame
  logic [2:0]                     rx_addr;
  logic                           rx_dm;
  logic [7:0]                     rx_info;
  logic                           addr_ok;
  logic                           recognised;
  logic                           same_frame;
  logic [1:0]                     rep_cnt_next;
  logic                           fire;
  obc_pkg::obc_eoc_frame_t        reply;
  logic [1:0]                     ps_send;
  logic [1:0]                     gasp_cnt_next;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0;
    case (paddr)
      `OBC_REG_CTRL: begin
        rd_mux[`OBC_CTRL_W-1:0] = ctrl_reg;
      end
      `OBC_REG_STATUS: begin
        rd_mux[`OBC_ST_FULL]    = loop_full_reg;
        rd_mux[`OBC_ST_B1]      = loop_b1_reg;
        rd_mux[`OBC_ST_B2]      = loop_b2_reg;
        rd_mux[`OBC_ST_CORRUPT] = corrupt_reg;
        rd_mux[`OBC_ST_NOTIFY]  = notify_reg;
        rd_mux[`OBC_ST_PS_LO]   = ps_sent_reg[0];
        rd_mux[`OBC_ST_PS_HI]   = ps_sent_reg[1];
        rd_mux[`OBC_ST_DEACT]   = (dea_cnt_reg == `OBC_DEA_MF);
        rd_mux[`OBC_ST_ACT]     = rx_act_reg;
      end
      `OBC_REG_EOC: begin
        rd_mux[11:0]  = last_frame_reg;
        rd_mux[13:12] = rep_cnt_reg;
      end
      `OBC_REG_FAR_END_ERROR_FLAG: begin
        rd_mux[`OBC_FAR_END_ERROR_FLAG_CNT_W-1:0] = far_end_error_flag_cnt_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // one wait state; writes land on the edge that samples pready high
  assign commit_wr = (apb_state_reg == obc_pkg::obc_apb_resp) && psel && penable && pwrite && addr_hit;
  assign far_end_error_flag_clr  = commit_wr && (paddr == `OBC_REG_FAR_END_ERROR_FLAG);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      apb_state_reg <= obc_pkg::obc_apb_idle;
      prdata_reg    <= 32'h0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      case (apb_state_reg)
        obc_pkg::obc_apb_idle: begin
          if (psel && penable) begin
            apb_state_reg <= obc_pkg::obc_apb_resp;
            prdata_reg    <= (pwrite || !addr_hit) ? 32'h0 : rd_mux;
            pslverr_reg   <= !addr_hit;
            pready_reg    <= 1'b1;
          end
        end
        obc_pkg::obc_apb_resp: begin
          apb_state_reg <= obc_pkg::obc_apb_idle;
          pready_reg    <= 1'b0;
          pslverr_reg   <= 1'b0;
        end
        default: begin
          apb_state_reg <= obc_pkg::obc_apb_idle;
          pready_reg    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= `OBC_CTRL_RESET;
    end else if (commit_wr && (paddr == `OBC_REG_CTRL) && pstrb[0]) begin
      ctrl_reg <= pwdata[`OBC_CTRL_W-1:0];
    end
  end

  // ------------------------------------------------------ operations channel
  always_comb begin
    rx_addr      = rx_eoc_frame[11:9];
    rx_dm        = rx_eoc_frame[8];
    rx_info      = rx_eoc_frame[7:0];
    addr_ok      = (rx_addr == `OBC_ADDR_NT) || (rx_addr == `OBC_ADDR_BCAST);
    recognised   = 1'b0;
    if (rx_dm == `OBC_DM_MSG) begin
      case (rx_info)
        `OBC_MSG_FULL, `OBC_MSG_B1, `OBC_MSG_B2, `OBC_MSG_REQ_CRC,
        `OBC_MSG_NOTE_CRC, `OBC_MSG_RTN, `OBC_MSG_HOLD: begin
          recognised = 1'b1;
        end
        default: begin
          recognised = 1'b0;
        end
      endcase
    end
    same_frame = (rep_cnt_reg != 2'h0) && (rx_eoc_frame == last_frame_reg);
    if (!same_frame) begin
      rep_cnt_next = 2'h1;
    end else if (rep_cnt_reg == `OBC_REPEAT) begin
      rep_cnt_next = `OBC_REPEAT;
    end else begin
      rep_cnt_next = 2'(rep_cnt_reg + 2'h1);
    end
    // only the exact third receipt starts an action
    fire = addr_ok && recognised && same_frame && (rep_cnt_next == `OBC_REPEAT)
           && (rep_cnt_reg != `OBC_REPEAT);
    if (!addr_ok) begin
      reply = {`OBC_ADDR_NT, `OBC_DM_MSG, `OBC_MSG_HOLD};
    end else if (!recognised && (rep_cnt_next == `OBC_REPEAT)) begin
      reply = {`OBC_ADDR_NT, `OBC_DM_MSG, `OBC_MSG_UTC};
    end else begin
      reply = rx_eoc_frame;
    end
  end

  // repetition tracking; return-to-normal empties it like a reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_frame_reg <= `OBC_EOC_RESET;
      rep_cnt_reg    <= 2'h0;
    end else if (rx_eoc_valid) begin
      if (fire && (rx_info == `OBC_MSG_RTN)) begin
        last_frame_reg <= `OBC_EOC_RESET;
        rep_cnt_reg    <= 2'h0;
      end else begin
        last_frame_reg <= rx_eoc_frame;
        rep_cnt_reg    <= rep_cnt_next;
      end
    end
  end

  // reply only to a received frame, in the next returning slot
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_eoc_frame_reg <= `OBC_EOC_RESET;
      tx_eoc_valid_reg <= 1'b0;
    end else begin
      tx_eoc_valid_reg <= rx_eoc_valid;
      if (rx_eoc_valid) begin
        tx_eoc_frame_reg <= reply;
      end
    end
  end

  // latched actions; several may be active at once
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loop_full_reg <= 1'b0;
      loop_b1_reg   <= 1'b0;
      loop_b2_reg   <= 1'b0;
      corrupt_reg   <= 1'b0;
      notify_reg    <= 1'b0;
    end else if (rx_eoc_valid && fire) begin
      case (rx_info)
        `OBC_MSG_FULL: begin
          loop_full_reg <= 1'b1;
        end
        `OBC_MSG_B1: begin
          loop_b1_reg <= 1'b1;
        end
        `OBC_MSG_B2: begin
          loop_b2_reg <= 1'b1;
        end
        `OBC_MSG_REQ_CRC: begin
          corrupt_reg <= 1'b1;
        end
        `OBC_MSG_NOTE_CRC: begin
          notify_reg <= 1'b1;
        end
        `OBC_MSG_RTN: begin
          loop_full_reg <= 1'b0;
          loop_b1_reg   <= 1'b0;
          loop_b2_reg   <= 1'b0;
          corrupt_reg   <= 1'b0;
          notify_reg    <= 1'b0;
        end
        default: begin
          // hold-state leaves everything as it is
        end
      endcase
    end
  end

  // ------------------------------------------------------- received overhead
  always_ff @(posedge core_clk) begin
    if (reset) begin
      far_end_error_flag_pending_reg <= 1'b1;
      dea_cnt_reg      <= 2'h0;
      rx_act_reg       <= 1'b0;
    end else if (rx_mf_done) begin
      far_end_error_flag_pending_reg <= !rx_crc_err;
      rx_act_reg       <= rx_act_bit;
      if (rx_dea_bit) begin
        dea_cnt_reg <= 2'h0;
      end else if (dea_cnt_reg != `OBC_DEA_MF) begin
        dea_cnt_reg <= 2'(dea_cnt_reg + 2'h1);
      end
    end
  end

  // far-end error count; a count in the clearing cycle survives
  always_ff @(posedge core_clk) begin
    if (reset) begin
      far_end_error_flag_cnt_reg <= '0;
    end else if (rx_mf_done && !rx_far_end_error_flag_bit) begin
      far_end_error_flag_cnt_reg <= far_end_error_flag_clr ? `OBC_FAR_END_ERROR_FLAG_CNT_W'(1) : `OBC_FAR_END_ERROR_FLAG_CNT_W'(far_end_error_flag_cnt_reg + 1'b1);
    end else if (far_end_error_flag_clr) begin
      far_end_error_flag_cnt_reg <= '0;
    end
  end

  // --------------------------------------------------------- sent overhead
  always_comb begin
    if ((power_sync == `OBC_PS_DYING)
        || ((gasp_cnt_reg != 2'h0) && (gasp_cnt_reg != `OBC_GASP_MF))) begin
      ps_send = `OBC_PS_DYING;
    end else begin
      ps_send = power_sync;
    end
    if (ps_send != `OBC_PS_DYING) begin
      gasp_cnt_next = 2'h0;
    end else if (gasp_cnt_reg == `OBC_GASP_MF) begin
      gasp_cnt_next = `OBC_GASP_MF;
    end else begin
      gasp_cnt_next = 2'(gasp_cnt_reg + 2'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gasp_cnt_reg <= 2'h0;
      ps_sent_reg  <= `OBC_PS_NORMAL;
    end else if (tx_mf_load) begin
      gasp_cnt_reg <= gasp_cnt_next;
      ps_sent_reg  <= ps_send;
    end
  end

  // bit n of tx_m4 is overhead bit four of basic frame n+1
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_m4_reg  <= 8'hFF;
      tx_m56_reg <= 4'hF;
    end else if (tx_mf_load) begin
      tx_m4_reg[0]   <= ctrl_reg[`OBC_CTRL_ACT];
      tx_m4_reg[1]   <= ps_send[1];
      tx_m4_reg[2]   <= ps_send[0];
      tx_m4_reg[3]   <= !ctrl_reg[`OBC_CTRL_TEST];
      tx_m4_reg[4]   <= ctrl_reg[`OBC_CTRL_CSO] || !sn3_active;
      tx_m4_reg[7:5] <= `OBC_RESERVED3;
      tx_m56_reg     <= {far_end_error_flag_pending_reg, `OBC_RESERVED3};
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign tx_eoc_valid   = tx_eoc_valid_reg;
  assign tx_eoc_frame   = tx_eoc_frame_reg;
  assign tx_m4_bits     = tx_m4_reg;
  assign tx_m56_bits    = tx_m56_reg;
  assign loop_full      = loop_full_reg;
  assign loop_b1        = loop_b1_reg;
  assign loop_b2        = loop_b2_reg;
  assign tx_corrupt_crc = corrupt_reg;

endmodule : obc_top

// File: verif/obc_top_asserts.sv
`timescale 1ns/1ps
module obc_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        rx_mf_done,
  input wire logic        rx_crc_err,
  input wire logic        rx_eoc_valid,
  input wire logic [11:0] rx_eoc_frame,
  input wire logic        tx_mf_load,
  input wire logic        tx_eoc_valid,
  input wire logic [11:0] tx_eoc_frame,
  input wire logic [7:0]  tx_m4_bits,
  input wire logic [3:0]  tx_m56_bits,
  input wire logic        loop_full,
  input wire logic        loop_b1,
  input wire logic        loop_b2,
  input wire logic        tx_corrupt_crc
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [11:0] last_reg;
  logic [1:0]  cnt_reg, cnt_next, gasp_reg;
  logic        far_end_error_flag_reg, mine, known, fire, rtn;
  logic [3:0]  acts;
  assign acts = {loop_full, loop_b1, loop_b2, tx_corrupt_crc};
  assign mine = rx_eoc_frame[11:9] inside {3'h0, 3'h7};
  assign known = rx_eoc_frame[8] && rx_eoc_frame[7:0] inside {8'h00, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'hFF};
  assign cnt_next = (rx_eoc_frame != last_reg) ? 2'h1 : (cnt_reg == 2'h3) ? 2'h3 : cnt_reg + 2'h1;
  assign fire = rx_eoc_valid && mine && known && cnt_reg == 2'h2 && rx_eoc_frame == last_reg;
  assign rtn = fire && rx_eoc_frame[7:0] == 8'hFF;
  // repeat count as the network sees it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_reg <= 12'h000;
      cnt_reg  <= 2'h0;
    end else if (rx_eoc_valid) begin
      last_reg <= rx_eoc_frame;
      cnt_reg  <= rtn ? 2'h0 : cnt_next;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset)
      far_end_error_flag_reg <= 1'b1;
    else if (rx_mf_done)
      far_end_error_flag_reg <= !rx_crc_err;
  end
  // loads seen while dying gasp is on the line
  always_ff @(posedge core_clk) begin
    if (reset || tx_m4_bits[2:1] != 2'h0)
      gasp_reg <= 2'h0;
    else if (tx_mf_load && gasp_reg != 2'h3)
      gasp_reg <= gasp_reg + 2'h1;
  end
  property act_p(logic sig, logic [7:0] code);
    $rose(sig) |-> $past(fire) && $past(rx_eoc_frame[7:0]) == code;
  endproperty
  chk_reply_next:
    assert property (rx_eoc_valid |=> tx_eoc_valid) else $error("reply missing");
  chk_echo_frame:
    assert property (rx_eoc_valid && mine && (known || cnt_next != 2'h3) |=> tx_eoc_frame == $past(rx_eoc_frame))
      else $error("echo wrong");
  chk_unable_reply:
    assert property (rx_eoc_valid && mine && !known && cnt_next == 2'h3 |=> tx_eoc_frame == 12'h1AA)
      else $error("unable reply wrong");
  chk_foreign_hold:
    assert property (rx_eoc_valid && !mine |=> tx_eoc_frame == 12'h100) else $error("hold reply wrong");
  chk_full_three:
    assert property (act_p(loop_full, 8'h50)) else $error("full loop start wrong");
  chk_b1_three:
    assert property (act_p(loop_b1, 8'h51)) else $error("b1 loop start wrong");
  chk_corrupt_three:
    assert property (act_p(tx_corrupt_crc, 8'h53)) else $error("corrupt start wrong");
  chk_rtn_clear:
    assert property (rtn |=> acts == 4'h0) else $error("actions kept");
  chk_latch_hold:
    assert property (|(~acts & $past(acts)) |-> $past(rtn)) else $error("action dropped");
  chk_far_end_error_flag_carry:
    assert property (tx_mf_load |=> tx_m56_bits[3] == $past(far_end_error_flag_reg)) else $error("far end flag wrong");
  chk_gasp_hold:
    assert property ($past(tx_m4_bits[2:1]) == 2'h0 && tx_m4_bits[2:1] != 2'h0 |-> gasp_reg == 2'h3)
      else $error("gasp too short");
  cover property (rtn);
  cover property ($rose(loop_b2));
  cover property (rx_eoc_valid && !mine);
endmodule : obc_chk

bind obc_top obc_chk i_obc_chk (
  .core_clk, .reset, .rx_mf_done, .rx_crc_err, .rx_eoc_valid, .rx_eoc_frame, .tx_mf_load, .tx_eoc_valid,
  .tx_eoc_frame, .tx_m4_bits, .tx_m56_bits, .loop_full, .loop_b1, .loop_b2, .tx_corrupt_crc
);

// File: verif/obc_net_model.sv
`timescale 1ns/1ps
module obc_net_model (
  input  wire logic        core_clk,
  output logic             rx_mf_done,
  output logic             rx_crc_err,
  output logic             rx_act_bit,
  output logic             rx_dea_bit,
  output logic             rx_far_end_error_flag_bit,
  output logic             rx_eoc_valid,
  output logic      [11:0] rx_eoc_frame,
  output logic             tx_mf_load
);
  initial begin
    rx_mf_done   = 1'b0;
    rx_crc_err   = 1'b0;
    rx_act_bit   = 1'b1;
    rx_dea_bit   = 1'b1;
    rx_far_end_error_flag_bit  = 1'b1;
    rx_eoc_valid = 1'b0;
    rx_eoc_frame = 12'hFFF;
    tx_mf_load   = 1'b0;
  end
  // released lines show the inverse, not a stale copy
  task automatic send(input logic [11:0] f);
    @(posedge core_clk);
    rx_eoc_valid <= 1'b1;
    rx_eoc_frame <= f;
    @(posedge core_clk);
    rx_eoc_valid <= 1'b0;
    rx_eoc_frame <= ~f;
  endtask : send
  task automatic multiframe(input logic err, input logic dea);
    @(posedge core_clk);
    rx_mf_done  <= 1'b1;
    rx_crc_err  <= err;
    rx_act_bit  <= 1'b1;
    rx_dea_bit  <= dea;
    rx_far_end_error_flag_bit <= 1'($urandom_range(1));
    @(posedge core_clk);
    rx_mf_done  <= 1'b0;
    rx_crc_err  <= !err;
    rx_dea_bit  <= !dea;
  endtask : multiframe
  task automatic deactivate;
    repeat (3) multiframe(1'b0, 1'b0);
  endtask : deactivate
  task automatic load;
    @(posedge core_clk);
    tx_mf_load <= 1'b1;
    @(posedge core_clk);
    tx_mf_load <= 1'b0;
  endtask : load
endmodule : obc_net_model

// File: verif/overhead_bits_and_ops_channel_tb.sv
`timescale 1ns/1ps
module overhead_bits_and_ops_channel_tb;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic        sn3_active, primary_power_ok, secondary_power_ok, tx_eoc_valid;
  logic        rx_mf_done, rx_crc_err, rx_act_bit, rx_dea_bit, rx_far_end_error_flag_bit, rx_eoc_valid, tx_mf_load;
  logic        loop_full, loop_b1, loop_b2, tx_corrupt_crc;
  logic [3:0]  pstrb, tx_m56_bits;
  logic [7:0]  paddr, tx_m4_bits, code;
  logic [11:0] rx_eoc_frame, tx_eoc_frame, f;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] exp_q[$];
  logic [7:0]  codes [5] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
  logic [3:0]  acts_exp [6] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'hF, 4'hF};
  int          mismatches, tests_run;

  obc_top i_obc_top (
    .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .rx_mf_done, .rx_crc_err, .rx_act_bit, .rx_dea_bit, .rx_far_end_error_flag_bit, .rx_eoc_valid, .rx_eoc_frame,
    .tx_mf_load, .sn3_active, .primary_power_ok, .secondary_power_ok, .tx_eoc_valid, .tx_eoc_frame,
    .tx_m4_bits, .tx_m56_bits, .loop_full, .loop_b1, .loop_b2, .tx_corrupt_crc
  );
  obc_net_model i_obc_net_model (
    .core_clk, .rx_mf_done, .rx_crc_err, .rx_act_bit, .rx_dea_bit, .rx_far_end_error_flag_bit, .rx_eoc_valid,
    .rx_eoc_frame, .tx_mf_load
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic eoc(input logic [11:0] fr, input logic [11:0] ex);
    exp_q.push_back(ex);
    i_obc_net_model.send(fr);
  endtask : eoc

  task automatic acts_are(input logic [3:0] a);
    @(negedge core_clk);
    check("actions", {loop_full, loop_b1, loop_b2, tx_corrupt_crc}, a);
  endtask : acts_are

  // c: {sn3, act, cold start only, test}, pw: {primary, secondary}
  task automatic step(input logic [3:0] c, input logic [1:0] pw, input logic e, input logic [7:0] m4);
    @(posedge core_clk);
    sn3_active         <= c[3];
    primary_power_ok   <= pw[1];
    secondary_power_ok <= pw[0];
    apb(1'b1, 8'h00, {29'h0, c[2:0]});
    i_obc_net_model.multiframe(e, 1'b1);
    i_obc_net_model.load();
    @(negedge core_clk);
    check("act flag", tx_m4_bits[0], m4[0]);
    check("power", tx_m4_bits[2:1], m4[2:1]);
    check("test flag", tx_m4_bits[3], m4[3]);
    check("cold start", tx_m4_bits[4], m4[4]);
    check("reserved", {tx_m4_bits[7:5], tx_m56_bits[2:0]}, 6'h3F);
    check("far end", tx_m56_bits[3], !e);
  endtask : step

  always @(negedge core_clk) begin
    if (tx_eoc_valid === 1'b1 && exp_q.size() == 0)
      check("spare reply", 1'b1, 1'b0);
    else if (tx_eoc_valid === 1'b1)
      check("reply", tx_eoc_frame, exp_q.pop_front());
  end

  initial begin
    void'($urandom(32'hEBA91D69));
    mismatches = 0;
    tests_run = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    sn3_active = 1'b0;
    primary_power_ok = 1'b1;
    secondary_power_ok = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    acts_are(4'h0);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    step(4'h4, 2'h3, 1'b1, 8'hFF);
    step(4'h9, 2'h1, 1'b0, 8'hE4);
    step(4'hE, 2'h2, 1'($urandom_range(1)), 8'hFB);
    step(4'h6, 2'h0, 1'b0, 8'hF9);
    for (int k = 0; k < 3; k++) step(4'h6, 2'h3, 1'($urandom_range(1)), k < 2 ? 8'hF9 : 8'hFF);
    i_obc_net_model.deactivate();
    apb(1'b0, 8'h04, 32'h0);
    check("deact seen", rd[7], 1'b1);
    // an interrupted run of repeats starts nothing
    repeat (2) eoc(12'h150, 12'h150);
    eoc(12'h151, 12'h151);
    eoc(12'h152, 12'h152);
    acts_are(4'h0);
    foreach (codes[i]) begin
      f = {(i == 2) ? 3'h7 : 3'h0, 1'b1, codes[i]};
      repeat (2) eoc(f, f);
      acts_are(acts_exp[i]);
      eoc(f, f);
      acts_are(acts_exp[i + 1]);
    end
    repeat (3) eoc(12'h100, 12'h100);
    acts_are(4'hF);
    apb(1'b0, 8'h04, 32'h0);
    check("status", rd, 32'h1FF);
    code = 8'h40 + 8'($urandom_range(15));
    for (int k = 0; k < 4; k++) eoc({4'h1, code}, k < 2 ? {4'h1, code} : 12'h1AA);
    for (int k = 0; k < 3; k++) eoc({4'h0, code}, k < 2 ? {4'h0, code} : 12'h1AA);
    f = {3'(1 + $urandom_range(5)), 9'h1FF};
    repeat (3) eoc(f, 12'h100);
    acts_are(4'hF);
    repeat (3) eoc(12'h1FF, 12'h1FF);
    acts_are(4'h0);
    eoc(12'h1FF, 12'h1FF);
    repeat (3) eoc(12'h150, 12'h150);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    acts_are(4'h0);
    apb(1'b0, 8'h08, 32'h0);
    check("repeat state", rd, 32'h0);
    for (int n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge core_clk);
    check("replies left", exp_q.size(), 0);
    summarize();
  end
endmodule : overhead_bits_and_ops_channel_tb
